// ==== logic/pbc_clock_ctrl.sv ====
// synthesizer programming registers, base clock selector and divider
`default_nettype none
// How it works
// - zero divider or multiplier acts as one
// - zero range disables synth, forces crystal
// - switch waits three edges each, output held
// - selected source halved to base clock
// - select bit picks crystal or vco clock
// - vco select refused while synth off
// - power-on cannot clear while vco selected
// - power and select never change together
// - programming values writable only while off
// - centre frequency is range times two to the power field times step
// - run-in-stop keeps oscillator running in stop
// - base clock has even duty cycle
// - lock detector drives lock-change interrupt
// - crystal clock passed through one sys_clk register
// - flag sets on lock toggle, ctrl read clears
// - reset powers synth on, select cleared
// - auto mode lets detector pick filter mode
module pbc_clock_ctrl (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// register port
	input wire logic [2:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdata,
	// source clocks, sampled as levels
	input wire logic crystal_clock,
	input wire logic vco_clock,
	// lock detector and integration unit
	input wire logic lockIn,
	input wire logic trackIn,
	input wire logic osc_enable_signal,
	input wire logic stopMode,
	input wire logic osc_run_in_stop,
	// to the integration unit and processor
	output logic base_clock_out,
	output logic crystalClockOut,
	output logic lock_change_irq,
	output logic oscRun,
	// to the analog core
	output logic synthEnable,
	output logic filterTrack,
	output logic [1:0] prescaleExp,
	output logic [1:0] vco_power_range_field,
	output logic [11:0] mulEff,
	output logic [3:0] refDivEff,
	output logic [31:0] vcoCenterHz
);
	import pbc_pkg::*;

	function automatic logic [31:0] centreHz(input logic [7:0] rng, input logic [1:0] pwr);
		centreHz = ({24'h000000, rng} << pwr) * STEP_HZ;
	endfunction

	////////////////////////////////////////////////////////////////
	// reset release
	logic [1:0] rstSync_q;
	logic rstN;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rstSync_q <= 2'h0;
		end else begin
			rstSync_q <= {rstSync_q[0], 1'b1};
		end
	end
	assign rstN = rstSync_q[1];

	////////////////////////////////////////////////////////////////
	// registers
	logic irqEn_q, irqEn_d, flag_q, flag_d, on_q, on_d, sel_q, sel_d;
	logic [1:0] pre_q, pre_d, vpr_q, vpr_d;
	logic auto_q, auto_d, acq_q, acq_d, lockPrev_q, lockPrev_d;
	logic [11:0] mul_q, mul_d;
	logic [7:0] rng_q, rng_d, rdata_q, rdata_d;
	logic [3:0] rdiv_q, rdiv_d;
	logic wrCtrl, rdCtrl, wOn, wSel, powerChange, rangeZero;

	always_comb begin
		wrCtrl = regWr && regAddr == ADDR_CTRL;
		rdCtrl = regRd && regAddr == ADDR_CTRL;
		wOn = regWdata[CTRL_ON];
		wSel = regWdata[CTRL_SEL];
		rangeZero = rng_q == 8'h00;
		irqEn_d = irqEn_q;
		on_d = on_q;
		sel_d = sel_q;
		pre_d = pre_q;
		vpr_d = vpr_q;
		auto_d = auto_q;
		acq_d = acq_q;
		mul_d = mul_q;
		rng_d = rng_q;
		rdiv_d = rdiv_q;
		lockPrev_d = lockIn;
		powerChange = 1'b0;
		if (wrCtrl) begin
			irqEn_d = regWdata[CTRL_IRQ_EN] & auto_q;
			on_d = sel_q | wOn;
			powerChange = on_d != on_q;
			if (on_q && !powerChange && !rangeZero) begin
				sel_d = wSel;
			end
			if (!on_q) begin
				pre_d = regWdata[CTRL_PRE +: 2];
				vpr_d = regWdata[CTRL_VPR +: 2];
			end
		end
		if (regWr && regAddr == ADDR_BW) begin
			auto_d = regWdata[BW_AUTO];
			if (!auto_q) begin
				acq_d = regWdata[BW_ACQ];
			end
			if (!regWdata[BW_AUTO]) begin
				irqEn_d = 1'b0;
			end
		end
		if (regWr && !on_q) begin
			unique case (regAddr)
				ADDR_MUL_HI: mul_d = {regWdata[3:0], mul_q[7:0]};
				ADDR_MUL_LO: mul_d = {mul_q[11:8], regWdata};
				ADDR_RANGE: rng_d = regWdata;
				ADDR_REFDIV: rdiv_d = regWdata[3:0];
				default: ;
			endcase
		end
		if (rangeZero) begin
			sel_d = 1'b0;
		end
		// set wins over the clearing read
		if (auto_q && lockIn != lockPrev_q) begin
			flag_d = 1'b1;
		end else if (rdCtrl) begin
			flag_d = 1'b0;
		end else begin
			flag_d = flag_q;
		end
		rdata_d = 8'h00;
		if (regRd) begin
			unique case (regAddr)
				ADDR_CTRL: begin
					rdata_d[CTRL_IRQ_EN] = irqEn_q;
					rdata_d[CTRL_FLAG] = flag_q & auto_q;
					rdata_d[CTRL_ON] = on_q;
					rdata_d[CTRL_SEL] = sel_q;
					rdata_d[CTRL_PRE +: 2] = pre_q;
					rdata_d[CTRL_VPR +: 2] = vpr_q;
				end
				ADDR_BW: begin
					rdata_d[BW_AUTO] = auto_q;
					rdata_d[BW_LOCK] = lockIn & auto_q;
					rdata_d[BW_ACQ] = auto_q ? trackIn : acq_q;
				end
				ADDR_MUL_HI: rdata_d = {4'h0, mul_q[11:8]};
				ADDR_MUL_LO: rdata_d = mul_q[7:0];
				ADDR_RANGE: rdata_d = rng_q;
				ADDR_REFDIV: rdata_d = {4'h0, rdiv_q};
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			irqEn_q <= 1'b0;
			flag_q <= 1'b0;
			on_q <= 1'b1;
			sel_q <= 1'b0;
			pre_q <= 2'h0;
			vpr_q <= 2'h0;
			auto_q <= 1'b0;
			acq_q <= 1'b0;
			lockPrev_q <= 1'b0;
			mul_q <= MUL_RESET;
			rng_q <= RANGE_RESET;
			rdiv_q <= REFDIV_RESET;
			rdata_q <= 8'h00;
		end else begin
			irqEn_q <= irqEn_d;
			flag_q <= flag_d;
			on_q <= on_d;
			sel_q <= sel_d;
			pre_q <= pre_d;
			vpr_q <= vpr_d;
			auto_q <= auto_d;
			acq_q <= acq_d;
			lockPrev_q <= lockPrev_d;
			mul_q <= mul_d;
			rng_q <= rng_d;
			rdiv_q <= rdiv_d;
			rdata_q <= rdata_d;
		end
	end
	assign regRdata = rdata_q;

	////////////////////////////////////////////////////////////////
	// transition control and divide by two
	// sources are sampled, so each must stay below a quarter of sys_clk
	pbc_sw_t sw_q, sw_d;
	logic src_q, src_d, base_q, base_d, xPrev_q, vPrev_q;
	logic [1:0] xCnt_q, xCnt_d, vCnt_q, vCnt_d;
	logic xRise, vRise, srcRise;

	always_comb begin
		xRise = crystal_clock & ~xPrev_q;
		vRise = vco_clock & ~vPrev_q;
		srcRise = src_q ? vRise : xRise;
		sw_d = sw_q;
		src_d = src_q;
		base_d = base_q;
		xCnt_d = xCnt_q;
		vCnt_d = vCnt_q;
		unique case (sw_q)
			SW_RUN: begin
				if (sel_q != src_q) begin
					sw_d = SW_WAIT;
					xCnt_d = 2'h0;
					vCnt_d = 2'h0;
				end else if (srcRise) begin
					base_d = ~base_q;
				end
			end
			SW_WAIT: begin
				// base clock held static until both sides are seen
				if (xRise && xCnt_q != SWITCH_EDGES) begin
					xCnt_d = xCnt_q + 2'h1;
				end
				if (vRise && vCnt_q != SWITCH_EDGES) begin
					vCnt_d = vCnt_q + 2'h1;
				end
				if (xCnt_q == SWITCH_EDGES && vCnt_q == SWITCH_EDGES) begin
					src_d = sel_q;
					sw_d = SW_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			sw_q <= SW_RUN;
			src_q <= 1'b0;
			base_q <= 1'b0;
			xCnt_q <= 2'h0;
			vCnt_q <= 2'h0;
			xPrev_q <= 1'b0;
			vPrev_q <= 1'b0;
		end else begin
			sw_q <= sw_d;
			src_q <= src_d;
			base_q <= base_d;
			xCnt_q <= xCnt_d;
			vCnt_q <= vCnt_d;
			xPrev_q <= crystal_clock;
			vPrev_q <= vco_clock;
		end
	end
	assign base_clock_out = base_q;

	////////////////////////////////////////////////////////////////
	// registered outputs to analog core and integration unit
	logic xOut_q, irq_q, oscRun_q, synEn_q, track_q;
	logic [1:0] preOut_q, vprOut_q;
	logic [11:0] mulEff_q;
	logic [3:0] rdivEff_q;
	logic [31:0] centre_q;
	logic irq_d, oscRun_d, synEn_d, track_d;
	logic [11:0] mulEff_d;
	logic [3:0] rdivEff_d;

	always_comb begin
		irq_d = flag_q & irqEn_q & auto_q;
		oscRun_d = osc_enable_signal | (osc_run_in_stop & stopMode);
		synEn_d = on_q & ~rangeZero & osc_enable_signal;
		track_d = auto_q ? trackIn : acq_q;
		mulEff_d = (mul_q == 12'h000) ? 12'h001 : mul_q;
		rdivEff_d = (rdiv_q == 4'h0) ? 4'h1 : rdiv_q;
	end

	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			xOut_q <= 1'b0;
			irq_q <= 1'b0;
			oscRun_q <= 1'b0;
			synEn_q <= 1'b0;
			track_q <= 1'b0;
			preOut_q <= 2'h0;
			vprOut_q <= 2'h0;
			mulEff_q <= MUL_RESET;
			rdivEff_q <= REFDIV_RESET;
			centre_q <= 32'h00000000;
		end else begin
			xOut_q <= crystal_clock;
			irq_q <= irq_d;
			oscRun_q <= oscRun_d;
			synEn_q <= synEn_d;
			track_q <= track_d;
			preOut_q <= pre_q;
			vprOut_q <= vpr_q;
			mulEff_q <= mulEff_d;
			rdivEff_q <= rdivEff_d;
			centre_q <= centreHz(rng_q, vpr_q);
		end
	end
	assign crystalClockOut = xOut_q;
	assign lock_change_irq = irq_q;
	assign oscRun = oscRun_q;
	assign synthEnable = synEn_q;
	assign filterTrack = track_q;
	assign prescaleExp = preOut_q;
	assign vco_power_range_field = vprOut_q;
	assign mulEff = mulEff_q;
	assign refDivEff = rdivEff_q;
	assign vcoCenterHz = centre_q;
endmodule
`default_nettype wire

// ==== logic/pbc_pkg.sv ====
// constants for the base clock select and synthesizer control block
`default_nettype none
package pbc_pkg;
	// register offsets on the plain register port
	localparam logic [2:0] ADDR_CTRL = 3'h0;
	localparam logic [2:0] ADDR_BW = 3'h1;
	localparam logic [2:0] ADDR_MUL_HI = 3'h2;
	localparam logic [2:0] ADDR_MUL_LO = 3'h3;
	localparam logic [2:0] ADDR_RANGE = 3'h4;
	localparam logic [2:0] ADDR_REFDIV = 3'h5;
	// control register field positions
	localparam int CTRL_IRQ_EN = 7;
	localparam int CTRL_FLAG = 6;
	localparam int CTRL_ON = 5;
	localparam int CTRL_SEL = 4;
	localparam int CTRL_PRE = 2;
	localparam int CTRL_VPR = 0;
	// bandwidth register field positions
	localparam int BW_AUTO = 7;
	localparam int BW_LOCK = 6;
	localparam int BW_ACQ = 5;
	// reset values
	localparam logic [11:0] MUL_RESET = 12'h040;
	localparam logic [7:0] RANGE_RESET = 8'h40;
	localparam logic [3:0] REFDIV_RESET = 4'h1;
	// source edges waited on each side of a switch
	localparam logic [1:0] SWITCH_EDGES = 2'h3;
	// nominal vco step in hz
	localparam logic [31:0] STEP_HZ = 32'h00009600;
	// transition control states
	typedef enum logic [1:0] {
		SW_RUN = 2'b01,
		SW_WAIT = 2'b10
	} pbc_sw_t;
endpackage
`default_nettype wire

// ==== bench/pbc_far_end.sv ====
// far-side model: crystal oscillator, vco and lock detector
`default_nettype none
module pbc_far_end (
	// clock and enables
	input wire logic sys_clk,
	input wire logic oscRun,
	input wire logic synthEnable,
	// clocks and detector levels
	output logic crystal_clock,
	output logic vco_clock,
	output logic lockIn,
	output logic trackIn
);
	timeunit 1ns;
	timeprecision 1ns;
	int xc = 0;
	int vc = 0;
	int up = 0;
	initial {crystal_clock, vco_clock, lockIn, trackIn} = 4'h0;
	// a period always completes, so no runt pulse on stop
	always @(posedge sys_clk) begin
		xc <= (oscRun || xc != 0) ? (xc + 1) % 8 : 0;
		crystal_clock <= xc >= 4;
		vc <= (synthEnable || vc != 0) ? (vc + 1) % 6 : 0;
		vco_clock <= vc >= 3;
		up <= synthEnable ? (up < 60 ? up + 1 : up) : 0;
		trackIn <= up >= 20;
		lockIn <= up >= 40;
	end
endmodule
`default_nettype wire

// ==== bench/pbc_clock_ctrl_monitor.sv ====
// concurrent checks on the clock control block ports
`default_nettype none
module pbc_clock_ctrl_monitor
	import pbc_pkg::*;
(
	// clock, reset, register port
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [2:0] regAddr,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [7:0] regRdata,
	// levels in
	input wire logic crystal_clock,
	input wire logic lockIn,
	input wire logic osc_enable_signal,
	input wire logic stopMode,
	input wire logic osc_run_in_stop,
	// outputs
	input wire logic base_clock_out,
	input wire logic crystalClockOut,
	input wire logic oscRun,
	input wire logic synthEnable,
	input wire logic [11:0] mulEff,
	input wire logic [3:0] refDivEff,
	input wire logic [31:0] vcoCenterHz
);
	// outputs sit at reset values for two edges after release
	logic [2:0] age_q;
	logic [2:0] age_d;
	always_comb age_d = (age_q == 3'h5) ? age_q : age_q + 3'h1;
	always_ff @(posedge sys_clk or negedge resetn)
		if (!resetn) age_q <= 3'h0;
		else age_q <= age_d;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn || age_q != 3'h5);
	////////////////////////////////////////////////////////////
	property p_osc; oscRun == $past(osc_enable_signal | (osc_run_in_stop & stopMode)); endproperty
	a_osc: assert property (p_osc) else $error("osc run wrong");
	property p_xtal; crystalClockOut == $past(crystal_clock); endproperty
	a_xtal: assert property (p_xtal) else $error("crystal copy wrong");
	property p_nz; mulEff != 12'h000 && refDivEff != 4'h0; endproperty
	a_nz: assert property (p_nz) else $error("zero divider");
	property p_flag; (regRd && regAddr == ADDR_CTRL && $stable(lockIn)) ##1 $stable(lockIn) ##1
		(regRd && regAddr == ADDR_CTRL && $stable(lockIn)) |=> !regRdata[CTRL_FLAG]; endproperty
	a_flag: assert property (p_flag) else $error("flag not cleared");
	property p_base; $changed(base_clock_out) |=> $stable(base_clock_out) [*3]; endproperty
	a_base: assert property (p_base) else $error("base toggles too fast");
	property p_rz; vcoCenterHz == 32'h0 |-> !synthEnable; endproperty
	a_rz: assert property (p_rz) else $error("synth on at zero range");
	property p_step; vcoCenterHz % STEP_HZ == 32'h0; endproperty
	a_step: assert property (p_step) else $error("centre off step");
	property p_lock; regWr && regAddr == ADDR_MUL_LO ##1 synthEnable |=> $stable(mulEff); endproperty
	a_lock: assert property (p_lock) else $error("multiplier written while on");
endmodule
bind pbc_clock_ctrl pbc_clock_ctrl_monitor pbc_clock_ctrl_monitor_inst (.*);
`default_nettype wire

// ==== bench/pbc_clock_ctrl_test.sv ====
// self-checking bench for the clock control block
`default_nettype none
module pbc_clock_ctrl_test;
	import pbc_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'b0, resetn = 1'b0, regWr = 1'b0, regRd = 1'b0;
	logic [2:0] regAddr = 3'h0;
	logic [7:0] regWdata = 8'h00, regRdata;
	logic osc_enable_signal = 1'b1, stopMode = 1'b0, osc_run_in_stop = 1'b0;
	logic crystal_clock, vco_clock, lockIn, trackIn, base_clock_out, crystalClockOut;
	logic lock_change_irq, oscRun, synthEnable, filterTrack;
	logic [1:0] prescaleExp, vco_power_range_field;
	logic [11:0] mulEff;
	logic [3:0] refDivEff;
	logic [31:0] vcoCenterHz;
	logic [7:0] rv [8] = '{8'h20, 8'h00, 8'h00, 8'h40, 8'h40, 8'h01, 8'h00, 8'h00};
	int n_fail = 0;
	int cmp_count = 0;
	pbc_clock_ctrl pbc_clock_ctrl_inst (.*);
	pbc_far_end pbc_far_end_inst (.*);
	always #10 sys_clk = ~sys_clk;
	////////////////////////////////////////////////////////////
	function automatic logic [31:0] nz(logic [11:0] x);
		return (x == 12'h0) ? 32'h1 : 32'(x);
	endfunction
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		{regWr, regAddr, regWdata} <= {1'b1, a, d};
		@(posedge sys_clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		{regRd, regAddr} <= {1'b1, a};
		@(posedge sys_clk);
		regRd <= 1'b0;
		#1 check(regRdata, e);
	endtask
	// half periods in ns seen on the base clock
	task automatic per(input logic [31:0] half);
		time t0;
		time t1;
		repeat (40) @(posedge sys_clk);
		@(posedge base_clock_out) t0 = $time;
		@(negedge base_clock_out) t1 = $time;
		check(32'(t1 - t0), half);
		@(posedge base_clock_out) t0 = $time;
		check(32'(t0 - t1), half);
	endtask
	task automatic final_report;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_fail++;
		final_report;
	end
	////////////////////////////////////////////////////////////
	initial begin
		logic [11:0] m;
		logic [3:0] r;
		logic [3:0] f;
		logic [7:0] l;
		logic b;
		void'($urandom(82852));
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge sys_clk);
		wr(3'h6, 8'hff);
		for (int i = 0; i < 8; i++) rd(3'(i), rv[i]);
		wr(ADDR_MUL_LO, 8'h55);
		wr(ADDR_CTRL, 8'h2f);
		rd(ADDR_MUL_LO, 8'h40);
		rd(ADDR_CTRL, 8'h20);
		wr(ADDR_CTRL, 8'h00);
		wr(ADDR_CTRL, 8'h30);
		rd(ADDR_CTRL, 8'h20);
		wr(ADDR_CTRL, 8'h00);
		wr(ADDR_CTRL, 8'h10);
		rd(ADDR_CTRL, 8'h00);
		for (int k = 0; k < 12; k++) begin
			m = (k == 0) ? 12'h0 : 12'($urandom);
			r = (k == 0) ? 4'h0 : 4'($urandom);
			l = 8'($urandom_range(1, 255));
			f = {2'($urandom), 2'($urandom_range(0, 2))};
			wr(ADDR_MUL_HI, {4'h0, m[11:8]});
			wr(ADDR_MUL_LO, m[7:0]);
			wr(ADDR_RANGE, l);
			wr(ADDR_REFDIV, {4'h0, r});
			wr(ADDR_CTRL, {4'h0, f});
			repeat (2) @(posedge sys_clk);
			#1 check(32'(mulEff), nz(m));
			check(32'(refDivEff), nz(12'(r)));
			check(vcoCenterHz, 32'(l) * (32'h1 << f[1:0]) * STEP_HZ);
			check(32'({prescaleExp, vco_power_range_field}), 32'(f));
		end
		wr(ADDR_CTRL, 8'h20);
		wr(ADDR_CTRL, 8'h30);
		// crystal rises inside this span, so a base clock that is not held would toggle
		#1 b = base_clock_out;
		repeat (12) @(posedge sys_clk);
		#1 check(32'(base_clock_out), 32'(b));
		wr(ADDR_CTRL, 8'h10);
		rd(ADDR_CTRL, 8'h30);
		per(32'h78);
		wr(ADDR_CTRL, 8'h20);
		per(32'ha0);
		wr(ADDR_CTRL, 8'h00);
		wr(ADDR_RANGE, 8'h00);
		wr(ADDR_CTRL, 8'h20);
		wr(ADDR_CTRL, 8'h30);
		rd(ADDR_CTRL, 8'h20);
		check(32'(synthEnable), 32'h0);
		wr(ADDR_CTRL, 8'h00);
		wr(ADDR_RANGE, 8'h40);
		for (int i = 0; i < 8; i++) begin
			@(posedge sys_clk);
			{osc_enable_signal, stopMode, osc_run_in_stop} <= 3'(i);
			repeat (2) @(posedge sys_clk);
			#1 check(32'(oscRun), 32'(i[2] | (i[1] & i[0])));
		end
		@(posedge sys_clk);
		osc_enable_signal <= 1'b1;
		// manual mode: the written acquisition bit drives the filter
		wr(ADDR_BW, 8'h20);
		rd(ADDR_BW, 8'h20);
		check(32'(filterTrack), 32'h1);
		wr(ADDR_BW, 8'h80);
		wr(ADDR_CTRL, 8'h80);
		wr(ADDR_CTRL, 8'ha0);
		for (int i = 0; i < 300 && lock_change_irq !== 1'b1; i++) begin
			@(posedge sys_clk);
			#1;
		end
		check(32'(lock_change_irq), 32'h1);
		rd(ADDR_BW, 8'he0);
		check(32'(filterTrack), 32'h1);
		rd(ADDR_CTRL, 8'he0);
		rd(ADDR_CTRL, 8'ha0);
		check(32'(lock_change_irq), 32'h0);
		final_report;
	end
endmodule
`default_nettype wire
